// [shared/output_compare_pkg.sv]
// constants and carrier types for the output compare channel
// Overview of operation
// - Mode code 011 selects toggle mode; matches need a non-off mode and a selected timer whose count equals the value.
// - Toggle mode drives the pin low on entry from any mode but set-high or force-low and inverts it on every later primary match.
// - A toggle lands one clock after its match and holds until the next toggle or a change to set-high, force-low or a pulse mode; disable keeps the level.
// - In toggle mode the event flag pulses two clocks after each pin toggle, once per toggle.
// - Reset clears the pin output logic to zero.
// - Switching from set-high or force-low mode into toggle keeps the current pin level.
// - Modes 100 and 101 use the primary match for the rising edge and the secondary for the falling.
// - Single-pulse mode 100 drives the pin low on entry and keeps it low until the primary match.
// - Single-pulse goes high one clock after the primary match, low one clock after the secondary match, then stays low.
// - With the period below the secondary value no falling edge occurs and the pin stays high.
// - Single-pulse sets the event flag two clocks after the trailing edge.
// - Codes 000 disable, 001 start low and set on match, 010 start high and clear on match.
// - The time base select bit chooses which of two timer counts is compared.
package output_compare_pkg;

    localparam int unsigned CNT_W = 16;
    localparam int unsigned MODE_W = 3;

    localparam logic [MODE_W-1:0] MODE_OFF = 3'h0;
    localparam logic [MODE_W-1:0] MODE_SET_HIGH = 3'h1;
    localparam logic [MODE_W-1:0] MODE_FORCE_LOW = 3'h2;
    localparam logic [MODE_W-1:0] MODE_TOGGLE = 3'h3;
    localparam logic [MODE_W-1:0] MODE_SINGLE_PULSE = 3'h4;
    localparam logic [MODE_W-1:0] MODE_CONT_PULSE = 3'h5;

    // event flag delay after a pin edge, in instruction clocks
    localparam int unsigned FLAG_DELAY = 2;

    typedef struct packed {
        logic [MODE_W-1:0] mode_field;
        logic              time_base_select;
    } channel_control_t;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] period;
    } time_base_t;

    // pulse-mode sequencer
    typedef enum logic [1:0] {
        PS_WAIT_RISE = 2'b00,
        PS_WAIT_FALL = 2'b01,
        PS_DONE      = 2'b11
    } pulse_state_t;

endpackage

// [src/output_compare_toggle_and_pulse.sv]
// one output compare channel: single, toggle and dual compare modes
`timescale 1ns/100ps
`default_nettype none
module output_compare_toggle_and_pulse (
    input  wire logic                                      ref_clk,
    input  wire logic                                      rstn,
    input  wire output_compare_pkg::channel_control_t      channel_control,
    input  wire logic [output_compare_pkg::CNT_W-1:0]      primary_compare_value,
    input  wire logic [output_compare_pkg::CNT_W-1:0]      secondary_compare_value,
    input  wire output_compare_pkg::time_base_t            time_base_a,
    input  wire output_compare_pkg::time_base_t            time_base_b,
    output logic                                           compare_output_pin,
    output logic                                           channel_event_flag
);

    logic [output_compare_pkg::MODE_W-1:0] mode_r;
    logic [output_compare_pkg::MODE_W-1:0] mode_nxt;
    logic                                  pin_r;
    logic                                  pin_nxt;
    logic [output_compare_pkg::FLAG_DELAY-1:0] evt_r;
    logic [output_compare_pkg::FLAG_DELAY-1:0] evt_nxt;
    output_compare_pkg::pulse_state_t      ps_r;
    output_compare_pkg::pulse_state_t      ps_nxt;
    output_compare_pkg::time_base_t        tb;
    logic                                  match_pri;
    logic                                  match_sec;
    logic                                  edge_evt;
    logic [output_compare_pkg::MODE_W-1:0] new_mode;

    // only the pulse-sequencer reset decodes dual modes here; the case statements decode them directly
    function automatic logic is_dual(input logic [output_compare_pkg::MODE_W-1:0] m);
        return (m == output_compare_pkg::MODE_SINGLE_PULSE) ||
               (m == output_compare_pkg::MODE_CONT_PULSE);
    endfunction

    assign new_mode = channel_control.mode_field;

    always_comb begin
        tb = channel_control.time_base_select ? time_base_b : time_base_a;
        match_pri = (mode_r != output_compare_pkg::MODE_OFF) &&
                    (tb.count == primary_compare_value);
        // a secondary value beyond the period never matches, so the pin stays high
        match_sec = (mode_r != output_compare_pkg::MODE_OFF) &&
                    (tb.count == secondary_compare_value);
    end

    always_comb begin
        mode_nxt = new_mode;
        pin_nxt  = pin_r;
        ps_nxt   = ps_r;
        edge_evt = 1'b0;
        if (new_mode != mode_r) begin
            // entry values take effect on the clock after the write
            ps_nxt = output_compare_pkg::PS_WAIT_RISE;
            unique case (new_mode)
                output_compare_pkg::MODE_SET_HIGH: begin
                    pin_nxt = 1'b0;
                end
                output_compare_pkg::MODE_FORCE_LOW: begin
                    pin_nxt = 1'b1;
                end
                output_compare_pkg::MODE_TOGGLE: begin
                    // from set-high or force-low the level carries over
                    if (mode_r != output_compare_pkg::MODE_SET_HIGH &&
                        mode_r != output_compare_pkg::MODE_FORCE_LOW) begin
                        pin_nxt = 1'b0;
                    end
                end
                output_compare_pkg::MODE_SINGLE_PULSE,
                output_compare_pkg::MODE_CONT_PULSE: begin
                    pin_nxt = 1'b0;
                end
                default: begin
                    // disabled or unsupported pwm codes: pin holds
                    pin_nxt = pin_r;
                end
            endcase
        end else begin
            unique case (mode_r)
                output_compare_pkg::MODE_SET_HIGH: begin
                    if (match_pri && !pin_r) begin
                        pin_nxt  = 1'b1;
                        edge_evt = 1'b1;
                    end
                end
                output_compare_pkg::MODE_FORCE_LOW: begin
                    if (match_pri && pin_r) begin
                        pin_nxt  = 1'b0;
                        edge_evt = 1'b1;
                    end
                end
                output_compare_pkg::MODE_TOGGLE: begin
                    if (match_pri) begin
                        pin_nxt  = ~pin_r;
                        edge_evt = 1'b1;
                    end
                end
                output_compare_pkg::MODE_SINGLE_PULSE,
                output_compare_pkg::MODE_CONT_PULSE: begin
                    unique case (ps_r)
                        output_compare_pkg::PS_WAIT_RISE: begin
                            if (match_pri) begin
                                pin_nxt = 1'b1;
                                ps_nxt  = output_compare_pkg::PS_WAIT_FALL;
                            end
                        end
                        output_compare_pkg::PS_WAIT_FALL: begin
                            if (match_sec) begin
                                pin_nxt  = 1'b0;
                                edge_evt = 1'b1;
                                ps_nxt   = (mode_r == output_compare_pkg::MODE_CONT_PULSE)
                                         ? output_compare_pkg::PS_WAIT_RISE
                                         : output_compare_pkg::PS_DONE;
                            end
                        end
                        output_compare_pkg::PS_DONE: begin
                            pin_nxt = 1'b0;
                        end
                        default: begin
                            ps_nxt = output_compare_pkg::PS_WAIT_RISE;
                        end
                    endcase
                end
                default: begin
                    pin_nxt = pin_r;
                end
            endcase
        end
        if (!is_dual(mode_nxt)) begin
            ps_nxt = output_compare_pkg::PS_WAIT_RISE;
        end
        // flag fires FLAG_DELAY clocks after the pin changes
        evt_nxt = {evt_r[output_compare_pkg::FLAG_DELAY-2:0], edge_evt};
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mode_r <= output_compare_pkg::MODE_OFF;
            pin_r  <= 1'b0;
            ps_r   <= output_compare_pkg::PS_WAIT_RISE;
            evt_r  <= '0;
            channel_event_flag <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            pin_r  <= pin_nxt;
            ps_r   <= ps_nxt;
            evt_r  <= evt_nxt;
            channel_event_flag <= evt_r[output_compare_pkg::FLAG_DELAY-1];
        end
    end

    assign compare_output_pin = pin_r;

endmodule
`default_nettype wire

// [testbench/output_compare_properties.sv]
// checker for the output compare channel
`timescale 1ns/100ps
`default_nettype none
module output_compare_properties (
    input wire logic                                 ref_clk,
    input wire logic                                 rstn,
    input wire output_compare_pkg::channel_control_t channel_control,
    input wire logic [15:0]                          primary_compare_value,
    input wire logic [15:0]                          secondary_compare_value,
    input wire output_compare_pkg::time_base_t       time_base_a,
    input wire output_compare_pkg::time_base_t       time_base_b,
    input wire logic                                 compare_output_pin,
    input wire logic                                 channel_event_flag
);
    logic [2:0]  m;
    logic [15:0] cnt;
    logic        pin;
    logic        flag;
    assign m = channel_control.mode_field;
    assign pin = compare_output_pin;
    assign flag = channel_event_flag;
    assign cnt = channel_control.time_base_select ? time_base_b.count : time_base_a.count;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // the edge of a mode change is not a match
    sequence tog_match;
        m == 3'h3 && $past(m) == 3'h3 && cnt == primary_compare_value;
    endsequence
    a_toggle_entry_low: assert property (m == 3'h3 && $past(m) == 3'h0 |=> !pin)
        else $error("toggle entry not low");
    a_toggle_keep_level: assert property (
        m == 3'h3 && $past(m) inside {3'h1, 3'h2} |=> $stable(pin))
        else $error("toggle entry lost level");
    a_toggle_inverts: assert property (tog_match |=> pin != $past(pin))
        else $error("no toggle after match");
    a_toggle_flag_delay: assert property (tog_match |-> ##3 flag)
        else $error("toggle flag late");
    a_pulse_entry_low: assert property (m == 3'h4 && $past(m) == 3'h0 |=> !pin)
        else $error("pulse entry not low");
    a_pulse_fall_edge: assert property (
        m == 3'h4 && $past(m) == 3'h4 && pin && cnt == secondary_compare_value |=> !pin)
        else $error("no falling edge");
    a_pulse_hold_high: assert property (
        m == 3'h4 && $past(m) == 3'h4 && pin && cnt != secondary_compare_value |=> pin)
        else $error("pulse fell early");
    a_pulse_flag_delay: assert property (
        m == 3'h4 && $past(m) == 3'h4 && $past(m, 2) == 3'h4 && $fell(pin) |-> ##2 flag)
        else $error("pulse flag late");
    a_reset_clears_pin: assert property ($rose(rstn) |-> !pin && !flag)
        else $error("pin not cleared by reset");
endmodule
bind output_compare_toggle_and_pulse output_compare_properties output_compare_properties_inst (.*);
`default_nettype wire

// [testbench/tb_output_compare_toggle_and_pulse.sv]
// testbench for the output compare channel
`timescale 1ns/100ps
`default_nettype none
module tb_output_compare_toggle_and_pulse;
    logic                                 ref_clk = 1'b0;
    logic                                 rstn = 1'b0;
    logic                                 run = 1'b0;
    logic [15:0]                          period = 16'h0009;
    logic [15:0]                          primary_compare_value = 16'h0005;
    logic [15:0]                          secondary_compare_value = 16'h0007;
    output_compare_pkg::channel_control_t channel_control = '0;
    output_compare_pkg::time_base_t       time_base_a;
    output_compare_pkg::time_base_t       time_base_b;
    logic                                 compare_output_pin;
    logic                                 channel_event_flag;
    int                                   fails = 0;
    int                                   comparisons = 0;
    int                                   cycles = 0;
    output_compare_toggle_and_pulse output_compare_toggle_and_pulse_inst (.*);
    timer_model timer_a_inst (.ref_clk, .rstn, .run, .period, .tb(time_base_a));
    timer_model timer_b_inst (.ref_clk, .rstn, .run, .period(16'h0003), .tb(time_base_b));
    always #25 ref_clk = ~ref_clk;
    task automatic print_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // the whole run needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            print_verdict();
        end
    end
    task automatic step(int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic check(logic exp, logic got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic set_mode(logic [2:0] m);
        channel_control.mode_field = m;
        step(1);
    endtask
    task automatic wait_cnt(logic [15:0] v);
        for (int i = 0; i < 40; i++) begin
            if ((channel_control.time_base_select ? time_base_b.count : time_base_a.count) == v)
                break;
            step(1);
        end
    endtask
    task automatic tog_step(logic exp);
        wait_cnt(primary_compare_value);
        step(1);
        check(exp, compare_output_pin);
        step(2);
        check(1'b1, channel_event_flag);
        step(1);
        check(1'b0, channel_event_flag);
    endtask
    task automatic pulse();
        wait_cnt(primary_compare_value);
        step(1);
        check(1'b1, compare_output_pin);
        wait_cnt(secondary_compare_value);
        step(1);
        check(1'b0, compare_output_pin);
    endtask
    initial begin
        step(20);
        rstn = 1'b1;
        check(1'b0, compare_output_pin);
        run = 1'b1;
        set_mode(3'h3);
        check(1'b0, compare_output_pin);
        tog_step(1'b1);
        tog_step(1'b0);
        primary_compare_value = 16'h0002;
        channel_control.time_base_select = 1'b1;
        tog_step(1'b1);
        primary_compare_value = 16'h0005;
        channel_control.time_base_select = 1'b0;
        // timer frozen off the match value so setup edges see no match
        run = 1'b0;
        for (int m = 1; m < 3; m++) begin
            set_mode(3'h0);
            set_mode(m[2:0]);
            check(m[1], compare_output_pin);
            set_mode(3'h3);
            check(m[1], compare_output_pin);
            run = 1'b1;
            tog_step(~m[1]);
            run = 1'b0;
        end
        set_mode(3'h0);
        set_mode(3'h4);
        check(1'b0, compare_output_pin);
        run = 1'b1;
        pulse();
        step(2);
        check(1'b1, channel_event_flag);
        step(20);
        check(1'b0, compare_output_pin);
        secondary_compare_value = 16'h000C;
        set_mode(3'h0);
        set_mode(3'h4);
        wait_cnt(primary_compare_value);
        step(25);
        check(1'b1, compare_output_pin);
        period = 16'h000F;
        wait_cnt(secondary_compare_value);
        step(1);
        check(1'b0, compare_output_pin);
        secondary_compare_value = 16'h0007;
        set_mode(3'h0);
        set_mode(3'h5);
        repeat (2) pulse();
        print_verdict();
    end
endmodule
`default_nettype wire

// [testbench/timer_model.sv]
// time base model: counts up to its period, then wraps to zero
`timescale 1ns/100ps
`default_nettype none
module timer_model (
    input  wire logic                          ref_clk,
    input  wire logic                          rstn,
    input  wire logic                          run,
    input  wire logic [15:0]                   period,
    output var output_compare_pkg::time_base_t tb
);
    logic [15:0] count_r;
    assign tb = '{count: count_r, period: period};
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            count_r <= 16'h0000;
        else if (run)
            count_r <= (count_r >= period) ? 16'h0000 : count_r + 16'h0001;
    end
endmodule
`default_nettype wire
